/* File: rtl/crf_pkg.sv */
// Purpose: shared constants and types for the can receive path
// Assumes: byte 0 of a frame is the top byte of the packed frame
// Notes:   pattern and mask byte k sit at bits [8k+7:8k]
package crf_pkg;
	localparam int         FIFO_DEPTH     = 5;
	localparam int         ENTRY_BYTES    = 15;
	localparam int         FRAME_W        = ENTRY_BYTES * 8;
	localparam int         NUM_FILT_BYTES = 8;
	localparam int         HIT_W          = 3;

	// acceptance modes, field of acceptance_control_reg
	localparam logic [1:0] MODE_TWO       = 2'h0;
	localparam logic [1:0] MODE_FOUR      = 2'h1;
	localparam logic [1:0] MODE_EIGHT     = 2'h2;
	localparam logic [1:0] MODE_CLOSED    = 2'h3;
	localparam int         IDAC_MODE_LSB  = 4;
	localparam int         IDAC_HIT_LSB   = 0;
	localparam int         CTL1_LOOPBACK  = 5;

	localparam logic [7:0] CTL1_RST       = 8'h01;
	localparam logic [7:0] BTR_RST        = 8'h00;
	localparam logic [1:0] MODE_RST       = MODE_TWO;
	localparam logic       CAN_RECESSIVE  = 1'b1;
	localparam logic [7:0] ERR_CNT_MAX    = 8'hff;

	// configuration write selects
	localparam logic [4:0] SEL_CTL1       = 5'h00;
	localparam logic [4:0] SEL_BTR0       = 5'h01;
	localparam logic [4:0] SEL_BTR1       = 5'h02;
	localparam logic [4:0] SEL_IDAC       = 5'h03;
	localparam logic [4:0] SEL_REC        = 5'h04;
	localparam logic [4:0] SEL_TEC        = 5'h05;
	localparam logic [1:0] SEL_GRP_PAT    = 2'h1;
	localparam logic [1:0] SEL_GRP_MSK    = 2'h2;

	typedef struct packed {
		logic [31:0] idr;
		logic [7:0]  dlr;
		logic [63:0] data;
		logic [15:0] tstamp;
	} crf_frame_t;

	typedef struct packed {
		crf_frame_t       frame;
		logic [HIT_W-1:0] hit;
	} crf_entry_t;

	typedef struct packed {
		logic       sof;
		logic       wr;
		logic [3:0] idx;
		logic [7:0] data;
		logic       done;
		logic       ok;
	} crf_rx_ev_t;

	typedef struct packed {
		logic       we;
		logic [4:0] sel;
		logic [7:0] data;
	} crf_cfg_wr_t;
endpackage : crf_pkg

/* File: rtl/crf_accept_filter.sv */
// Purpose: identifier acceptance filter, purely combinational
// Assumes: identifier bytes laid out as the receive buffer holds them
// Notes:   a set mask bit is a don't-care; lowest hit wins
`timescale 1ns/1ps
module crf_accept_filter (
	input  wire logic [31:0]               i_idr,
	input  wire logic [63:0]               i_pat,
	input  wire logic [63:0]               i_msk,
	input  wire logic [1:0]                i_mode,
	output logic                           o_hit,
	output logic [crf_pkg::HIT_W-1:0]      o_hit_idx
);
	import crf_pkg::*;

	logic [NUM_FILT_BYTES-1:0] m32;
	logic [NUM_FILT_BYTES-1:0] m16;
	logic [NUM_FILT_BYTES-1:0] m8;
	logic [NUM_FILT_BYTES-1:0] hits;

	for (genvar k = 0; k < NUM_FILT_BYTES; k++) begin : g_byte
		assign m32[k] = &(~(i_idr[31-8*(k%4) -: 8] ^ i_pat[8*k +: 8]) | i_msk[8*k +: 8]);
		assign m16[k] = &(~(i_idr[31-8*(k%2) -: 8] ^ i_pat[8*k +: 8]) | i_msk[8*k +: 8]);
		assign m8[k]  = &(~(i_idr[31 -: 8] ^ i_pat[8*k +: 8]) | i_msk[8*k +: 8]);
	end

	always_comb begin
		unique case (i_mode)
			MODE_TWO:    hits = {6'h00, &m32[7:4], &m32[3:0]};
			MODE_FOUR:   hits = {4'h0, &m16[7:6], &m16[5:4], &m16[3:2], &m16[1:0]};
			MODE_EIGHT:  hits = m8;
			MODE_CLOSED: hits = 8'h00;
		endcase
	end

	always_comb begin
		o_hit     = |hits;
		o_hit_idx = '0;
		for (int i = NUM_FILT_BYTES - 1; i >= 0; i--) begin
			if (hits[i]) begin
				o_hit_idx = HIT_W'(i);
			end
		end
	end
endmodule : crf_accept_filter

/* File: rtl/crf_rx_fifo.sv */
// Purpose: receive frame fifo, head entry is the foreground buffer
// Assumes: push and pop may fall in the same cycle
// Notes:   o_next_head and o_next_count show the state after this edge
`timescale 1ns/1ps
module crf_rx_fifo #(
	parameter int DEPTH = crf_pkg::FIFO_DEPTH
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire logic                       i_push,
	input  wire crf_pkg::crf_entry_t        i_entry,
	input  wire logic                       i_pop,
	output logic                            o_full,
	output logic [$clog2(DEPTH+1)-1:0]      o_count,
	output logic [$clog2(DEPTH+1)-1:0]      o_next_count,
	output crf_pkg::crf_entry_t             o_next_head
);
	import crf_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	crf_entry_t    mem [DEPTH];
	logic [PW-1:0] wp;
	logic [PW-1:0] rp;
	logic [PW-1:0] next_rp;
	logic          do_push;
	logic          do_pop;

	assign o_full       = o_count == CW'(DEPTH);
	assign do_push      = i_push && !o_full;
	assign do_pop       = i_pop && (o_count != '0);
	assign next_rp      = !do_pop ? rp : (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
	assign o_next_count = o_count + CW'(do_push) - CW'(do_pop);
	// arrival order: head moves on only by pop
	assign o_next_head  = (do_push && next_rp == wp) ? i_entry : mem[next_rp];

	always_ff @(posedge i_clk_sys) begin
		if (do_push) begin
			mem[wp] <= i_entry;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wp      <= '0;
			rp      <= '0;
			o_count <= '0;
		end else begin
			if (do_push) begin
				wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			rp      <= next_rp;
			o_count <= o_next_count;
		end
	end
endmodule : crf_rx_fifo

/* File: rtl/crf_can_rx.sv */
// Purpose: can receive path with fifo, acceptance filter and config protection
// Assumes: frame events come from the bit engine on the same clock
// Notes:   foreground buffer is the fifo head, mirrored into output flops
// What this block does
// - keep received frames in a five-entry fifo of fifteen-byte entries
// - receiver-full flag is set while foreground buffer holds an accepted frame
// - write frame bytes into background buffer while filter evaluates it
// - on accepted valid frame push to fifo, set flag, raise unmasked interrupt
// - invalid or rejected frames are not queued and get overwritten
// - own transmitted frame outside loop-back is captured, never queued, interrupted on or acknowledged
// - in loop-back own frames are treated like any received frame
// - after lost arbitration the frame is received normally
// - accepted frame into full fifo is dropped and flags overrun
// - full fifo does not block transmit; acceptance resumes when space frees
// - pattern registers hold identifier; set mask bits are don't-care
// - three-bit hit index names lowest matching filter
// - two-filter mode compares full 32-bit banks, hits 0 and 1
// - four-filter mode compares 16-bit halves, hits 0 to 3
// - eight-filter mode compares first identifier byte, hits 0 to 7
// - closed mode never fills foreground buffer nor sets the flag
// - software writes to error counters are ignored
// - configuration and filter registers writable only in init mode
// - transmit pin forced recessive in power-down or init mode
// - module enable takes only the first write in normal modes
`timescale 1ns/1ps
module crf_can_rx (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire crf_pkg::crf_rx_ev_t        i_rx,
	input  wire logic                       i_tx_active,
	input  wire logic                       i_arb_lost,
	input  wire logic                       i_tx_bit,
	input  wire logic [15:0]                i_timer,
	input  wire logic                       i_time_enable,
	input  wire crf_pkg::crf_cfg_wr_t       i_cfg,
	input  wire logic                       i_init_request,
	input  wire logic                       i_powerdown,
	input  wire logic                       i_enable_wr,
	input  wire logic                       i_enable_data,
	input  wire logic                       i_special_mode,
	input  wire logic                       i_rx_full_clr,
	input  wire logic                       i_rx_irq_en,
	input  wire logic                       i_overrun_clr,
	input  wire logic                       i_err_irq_en,
	input  wire logic                       i_rx_err_inc,
	input  wire logic                       i_rx_err_dec,
	input  wire logic                       i_tx_err_inc,
	input  wire logic                       i_tx_err_dec,
	output crf_pkg::crf_frame_t             o_foreground_rx_buffer,
	output logic                            o_rx_full_flag,
	output logic [crf_pkg::HIT_W-1:0]       o_filter_hit_index,
	output logic                            o_rx_irq,
	output logic                            o_overrun_flag,
	output logic                            o_err_irq,
	output logic                            o_init_acknowledge,
	output logic                            o_can_tx_pin,
	output logic                            o_ack_enable,
	output logic                            o_module_enable_bit,
	output logic [7:0]                      o_control_reg_1,
	output logic [7:0]                      o_bit_timing_reg_0,
	output logic [7:0]                      o_bit_timing_reg_1,
	output logic [7:0]                      o_acceptance_control_reg,
	output logic [7:0]                      o_rx_err_cnt,
	output logic [7:0]                      o_tx_err_cnt
);
	import crf_pkg::*;
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	typedef enum logic {RX_IDLE, RX_BUSY} crf_rx_state_t;

	crf_rx_state_t    rx_state;
	crf_frame_t       background_rx_buffer;
	crf_entry_t       entry;
	crf_entry_t       next_head;
	logic [63:0]      acceptance_pattern_regs;
	logic [63:0]      acceptance_mask_regs;
	logic [1:0]       filt_mode;
	logic             filt_hit;
	logic [HIT_W-1:0] filt_idx;
	logic             own_frame;
	logic             next_own_frame;
	logic             self_drop;
	logic             next_init_ack;
	logic             in_init;
	logic             cfg_ok;
	logic             accept;
	logic             push;
	logic             pop;
	logic             overrun_ev;
	logic             next_overrun;
	logic             fifo_full;
	logic [CW-1:0]    fifo_count;
	logic [CW-1:0]    next_count;
	logic             enable_written;

	////////////////////////////////////////////////////////////////
	// frame acceptance decisions

	assign next_own_frame = i_rx.sof ? i_tx_active : (own_frame && !i_arb_lost);
	assign self_drop      = own_frame && !o_control_reg_1[CTL1_LOOPBACK];
	assign in_init        = i_init_request && o_init_acknowledge;
	assign accept         = i_rx.done && i_rx.ok && filt_hit && !self_drop && !in_init;
	assign push           = accept && !fifo_full;
	assign overrun_ev     = accept && fifo_full;
	assign pop            = i_rx_full_clr && o_rx_full_flag;
	assign next_overrun   = overrun_ev || (o_overrun_flag && !i_overrun_clr);
	assign next_init_ack  = i_init_request && (rx_state == RX_IDLE || o_init_acknowledge);
	assign cfg_ok         = i_cfg.we && in_init;

	always_comb begin
		entry.frame = background_rx_buffer;
		entry.hit   = filt_idx;
		if (i_time_enable) begin
			entry.frame.tstamp = i_timer;
		end
	end

	crf_accept_filter u_filter (
		.i_idr     (background_rx_buffer.idr),
		.i_pat     (acceptance_pattern_regs),
		.i_msk     (acceptance_mask_regs),
		.i_mode    (filt_mode),
		.o_hit     (filt_hit),
		.o_hit_idx (filt_idx)
	);

	crf_rx_fifo #(
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (i_rst),
		.i_push       (push),
		.i_entry      (entry),
		.i_pop        (pop),
		.o_full       (fifo_full),
		.o_count      (fifo_count),
		.o_next_count (next_count),
		.o_next_head  (next_head)
	);

	////////////////////////////////////////////////////////////////
	// background buffer, written while the filter watches it

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_state             <= RX_IDLE;
			background_rx_buffer <= '0;
			own_frame            <= 1'b0;
		end else begin
			own_frame <= next_own_frame;
			if (i_rx.sof) begin
				rx_state             <= RX_BUSY;
				background_rx_buffer <= '0;
			end else if (i_rx.done) begin
				rx_state <= RX_IDLE;
			end
			if (i_rx.wr && !i_rx.sof && i_rx.idx < 4'(ENTRY_BYTES)) begin
				background_rx_buffer[FRAME_W-1-8*i_rx.idx -: 8] <= i_rx.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// foreground view and flags

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_foreground_rx_buffer <= '0;
			o_filter_hit_index     <= '0;
			o_rx_full_flag         <= 1'b0;
			o_rx_irq               <= 1'b0;
		end else begin
			o_foreground_rx_buffer <= next_head.frame;
			o_filter_hit_index     <= next_head.hit;
			o_rx_full_flag         <= next_count != '0;
			o_rx_irq               <= (next_count != '0) && i_rx_irq_en;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_overrun_flag <= 1'b0;
			o_err_irq      <= 1'b0;
		end else begin
			o_overrun_flag <= next_overrun;
			o_err_irq      <= next_overrun && i_err_irq_en;
		end
	end

	////////////////////////////////////////////////////////////////
	// init handshake, pin protection and acknowledge gating

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_init_acknowledge <= 1'b0;
			o_can_tx_pin       <= CAN_RECESSIVE;
			o_ack_enable       <= 1'b0;
		end else begin
			o_init_acknowledge <= next_init_ack;
			// transmit keeps running whatever the fifo level
			o_can_tx_pin <= (next_init_ack || i_powerdown) ? CAN_RECESSIVE : i_tx_bit;
			o_ack_enable <= !(next_own_frame && !o_control_reg_1[CTL1_LOOPBACK]);
		end
	end

	////////////////////////////////////////////////////////////////
	// locked configuration registers

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_control_reg_1         <= CTL1_RST;
			o_bit_timing_reg_0      <= BTR_RST;
			o_bit_timing_reg_1      <= BTR_RST;
			filt_mode               <= MODE_RST;
			acceptance_pattern_regs <= '0;
			acceptance_mask_regs    <= '0;
		end else if (cfg_ok) begin
			if (i_cfg.sel == SEL_CTL1) begin
				o_control_reg_1 <= i_cfg.data;
			end
			if (i_cfg.sel == SEL_BTR0) begin
				o_bit_timing_reg_0 <= i_cfg.data;
			end
			if (i_cfg.sel == SEL_BTR1) begin
				o_bit_timing_reg_1 <= i_cfg.data;
			end
			if (i_cfg.sel == SEL_IDAC) begin
				filt_mode <= i_cfg.data[IDAC_MODE_LSB +: 2];
			end
			if (i_cfg.sel[4:3] == SEL_GRP_PAT) begin
				acceptance_pattern_regs[8*i_cfg.sel[2:0] +: 8] <= i_cfg.data;
			end
			if (i_cfg.sel[4:3] == SEL_GRP_MSK) begin
				acceptance_mask_regs[8*i_cfg.sel[2:0] +: 8] <= i_cfg.data;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_acceptance_control_reg <= '0;
		end else begin
			o_acceptance_control_reg                          <= '0;
			o_acceptance_control_reg[IDAC_MODE_LSB +: 2]      <= filt_mode;
			o_acceptance_control_reg[IDAC_HIT_LSB +: HIT_W]   <= next_head.hit;
		end
	end

	////////////////////////////////////////////////////////////////
	// write-once enable and hardware-only error counters

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_module_enable_bit <= 1'b0;
			enable_written      <= 1'b0;
		end else if (i_enable_wr && (!enable_written || i_special_mode)) begin
			o_module_enable_bit <= i_enable_data;
			enable_written      <= 1'b1;
		end
	end

	// SEL_REC and SEL_TEC writes deliberately land nowhere
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rx_err_cnt <= '0;
			o_tx_err_cnt <= '0;
		end else begin
			if (i_rx_err_inc && o_rx_err_cnt != ERR_CNT_MAX) begin
				o_rx_err_cnt <= o_rx_err_cnt + 1'b1;
			end else if (i_rx_err_dec && o_rx_err_cnt != '0) begin
				o_rx_err_cnt <= o_rx_err_cnt - 1'b1;
			end
			if (i_tx_err_inc && o_tx_err_cnt != ERR_CNT_MAX) begin
				o_tx_err_cnt <= o_tx_err_cnt + 1'b1;
			end else if (i_tx_err_dec && o_tx_err_cnt != '0) begin
				o_tx_err_cnt <= o_tx_err_cnt - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	property p_accept_sets_flag;
		accept && !fifo_full |=> o_rx_full_flag && fifo_count == $past(fifo_count) + 1'b1 - $past(pop);
	endproperty
	a_accept_sets_flag: assert property (p_accept_sets_flag) else $error("accepted frame not queued");

	property p_overrun;
		accept && fifo_full |=> o_overrun_flag && fifo_count == CW'(FIFO_DEPTH) - $past(pop);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_own_not_queued;
		i_rx.done && self_drop |=> fifo_count <= $past(fifo_count);
	endproperty
	a_own_not_queued: assert property (p_own_not_queued) else $error("own frame queued");

	property p_invalid_dropped;
		i_rx.done && !(i_rx.ok && filt_hit) |=> fifo_count <= $past(fifo_count);
	endproperty
	a_invalid_dropped: assert property (p_invalid_dropped) else $error("invalid frame queued");

	property p_closed;
		filt_mode == MODE_CLOSED && !o_rx_full_flag |=> !o_rx_full_flag;
	endproperty
	a_closed: assert property (p_closed) else $error("flag set in closed mode");

	property p_lock;
		i_cfg.we && !in_init |=> $stable(o_control_reg_1) && $stable(o_bit_timing_reg_0)
			&& $stable(acceptance_pattern_regs) && $stable(filt_mode);
	endproperty
	a_lock: assert property (p_lock) else $error("config changed outside init");

	property p_tx_recessive;
		o_init_acknowledge || $past(i_powerdown) |-> o_can_tx_pin == CAN_RECESSIVE;
	endproperty
	a_tx_recessive: assert property (p_tx_recessive) else $error("tx pin not recessive");

	property p_enable_once;
		enable_written && !i_special_mode && i_enable_wr |=> $stable(o_module_enable_bit);
	endproperty
	a_enable_once: assert property (p_enable_once) else $error("enable rewritten");

	property p_counter_locked;
		i_cfg.we && i_cfg.sel == SEL_REC && !i_rx_err_inc && !i_rx_err_dec |=> $stable(o_rx_err_cnt);
	endproperty
	a_counter_locked: assert property (p_counter_locked) else $error("error counter written");

	property p_advance;
		pop && fifo_count > CW'(1) |=> o_rx_full_flag ##1 o_rx_full_flag || $past(pop);
	endproperty
	a_advance: assert property (p_advance) else $error("next frame not presented");

	c_accept:   cover property (push);
	c_overrun:  cover property (overrun_ev);
	c_loopback: cover property (push && own_frame);
	c_advance:  cover property (pop && fifo_count > CW'(1));
endmodule : crf_can_rx

/* File: tb/crf_frame_src.sv */
// Purpose: far-side bit engine model feeding receive events
// Assumes: one frame at a time, bytes sent in index order
// Notes:   data line is inverted on each gap cycle and on the done cycle
`timescale 1ns/1ps
module crf_frame_src (
	input  wire logic           i_clk_sys,
	output crf_pkg::crf_rx_ev_t o_ev,
	output logic                o_tx_active,
	output logic                o_arb_lost
);
	import crf_pkg::*;
	initial begin
		o_ev = '0;
		o_tx_active = 1'b0;
		o_arb_lost = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic send(input logic [31:0] idr, input logic ok, input logic own, input logic lose, input int gap);
		logic [119:0] img;
		img = {idr, 8'h08, idr, ~idr, 16'h0000};
		@(posedge i_clk_sys);
		o_ev.sof <= 1'b1;
		o_tx_active <= own;
		for (int k = 0; k < 15; k++) begin
			@(posedge i_clk_sys);
			o_ev.sof <= 1'b0;
			o_ev.wr <= 1'b1;
			o_ev.idx <= 4'(k);
			o_ev.data <= img[119-8*k -: 8];
			o_arb_lost <= lose && k == 2;
			o_tx_active <= own && !(lose && k > 2);
			repeat (gap) begin
				@(posedge i_clk_sys);
				o_ev.wr <= 1'b0;
				o_ev.data <= ~o_ev.data;
				o_arb_lost <= 1'b0;
			end
		end
		@(posedge i_clk_sys);
		o_ev.wr <= 1'b0;
		o_ev.done <= 1'b1;
		o_ev.ok <= ok;
		o_arb_lost <= 1'b0;
		o_ev.data <= ~o_ev.data;
		@(posedge i_clk_sys);
		o_ev.done <= 1'b0;
		o_ev.ok <= 1'b0;
		o_tx_active <= 1'b0;
	endtask : send
endmodule : crf_frame_src

/* File: tb/crf_can_rx_tb.sv */
// Purpose: self-checking bench for the can receive path
// Assumes: frames come from the bit engine model one at a time
// Notes:   filter expectations are worked out by exp_hit
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module crf_can_rx_tb;
	import crf_pkg::*;
	logic clk = 1'b0, rst = 1'b1, init_req, pd, en_wr, en_data, spec, clr, rxirq_en, ovr_clr, rx_inc, ack_low, txbit;
	logic [15:0] timer;
	crf_cfg_wr_t cfg_wr;
	crf_rx_ev_t ev;
	crf_frame_t fg;
	logic tx_act, arb_lost, full, rxirq, ovr, errirq, iack, txpin, acken, module_enable_bit;
	logic [2:0] hit;
	logic [7:0] ctl1, idac, rec, tec;
	logic [63:0] pat, msk;
	logic [31:0] lfsr_q = 32'h3f, r, idr;
	logic [31:0] q [7];
	logic [3:0] e;
	logic [1:0] m;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	initial forever #50 clk = ~clk;
	crf_frame_src u_crf_frame_src (.i_clk_sys(clk), .o_ev(ev), .o_tx_active(tx_act), .o_arb_lost(arb_lost));
	crf_can_rx u_crf_can_rx (.i_clk_sys(clk), .i_rst(rst), .i_rx(ev), .i_tx_active(tx_act),
		.i_arb_lost(arb_lost), .i_tx_bit(txbit), .i_timer(timer), .i_time_enable(1'b1), .i_cfg(cfg_wr),
		.i_init_request(init_req), .i_powerdown(pd), .i_enable_wr(en_wr), .i_enable_data(en_data),
		.i_special_mode(spec), .i_rx_full_clr(clr), .i_rx_irq_en(rxirq_en), .i_overrun_clr(ovr_clr),
		.i_err_irq_en(1'b1), .i_rx_err_inc(rx_inc), .i_rx_err_dec(1'b0), .i_tx_err_inc(1'b0),
		.i_tx_err_dec(1'b0), .o_foreground_rx_buffer(fg), .o_rx_full_flag(full), .o_filter_hit_index(hit),
		.o_rx_irq(rxirq), .o_overrun_flag(ovr), .o_err_irq(errirq), .o_init_acknowledge(iack),
		.o_can_tx_pin(txpin), .o_ack_enable(acken), .o_module_enable_bit(module_enable_bit), .o_control_reg_1(ctl1),
		.o_bit_timing_reg_0(), .o_bit_timing_reg_1(), .o_acceptance_control_reg(idac),
		.o_rx_err_cnt(rec), .o_tx_err_cnt(tec));
	always @(posedge clk) if (tx_act && !acken) ack_low <= 1'b1;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		for (int k = 0; k < 32; k++) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction : rnd
	function automatic logic [3:0] exp_hit(logic [1:0] md, logic [31:0] id);
		int n;
		int w;
		logic ok;
		n = (md == MODE_TWO) ? 2 : (md == MODE_FOUR) ? 4 : (md == MODE_EIGHT) ? 8 : 0;
		w = (n > 0) ? 8 / n : 1;
		for (int f = 0; f < n; f++) begin
			ok = 1'b1;
			for (int j = 0; j < w; j++)
				if (((id[31-8*j -: 8] ^ pat[8*(f*w+j) +: 8]) & ~msk[8*(f*w+j) +: 8]) != 8'h00) ok = 1'b0;
			if (ok) return {1'b1, 3'(f)};
		end
		return 4'h0;
	endfunction : exp_hit
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic cfg_put(input logic [4:0] s, input logic [7:0] d);
		@(posedge clk) cfg_wr <= '{1'b1, s, d};
		@(posedge clk) cfg_wr.we <= 1'b0;
		#1;
	endtask : cfg_put
	task automatic en_put(input logic d);
		@(posedge clk) begin
			en_wr <= 1'b1;
			en_data <= d;
		end
		@(posedge clk) en_wr <= 1'b0;
		#1;
	endtask : en_put
	task automatic set_init(input logic v);
		int n = 0;
		@(posedge clk) init_req <= v;
		while (iack !== v && n < 40) begin
			@(posedge clk);
			n++;
		end
		tick(1);
		`CHK(iack, v)
	endtask : set_init
	task automatic set_mode(input logic [1:0] md);
		set_init(1'b1);
		cfg_put(SEL_IDAC, {2'b00, md, 4'h0});
		for (int k = 0; k < 8; k++) begin
			cfg_put({SEL_GRP_PAT, 3'(k)}, pat[8*k +: 8]);
			cfg_put({SEL_GRP_MSK, 3'(k)}, msk[8*k +: 8]);
		end
		`CHK(idac[5:4], md)
		set_init(1'b0);
	endtask : set_mode
	task automatic frame(input logic [31:0] id, input logic ok, input logic own, input logic lose, input int gap);
		u_crf_frame_src.send(id, ok, own, lose, gap);
		tick(2);
	endtask : frame
	task automatic take(input logic [31:0] id, input logic [2:0] h);
		`CHK(full, 1'b1)
		`CHK(rxirq, rxirq_en)
		`CHK(fg, {id, 8'h08, id, ~id, timer})
		`CHK(hit, h)
		`CHK(idac[2:0], h)
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		#1;
	endtask : take
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		{init_req, pd, en_wr, en_data, spec, clr, ovr_clr, rx_inc, ack_low, txbit} = '0;
		rxirq_en = 1'b1;
		timer = 16'h0000;
		cfg_wr = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		`CHK(full, 1'b0)
		`CHK(ctl1, CTL1_RST)
		`CHK(module_enable_bit, 1'b0)
		en_put(1'b1);
		`CHK(module_enable_bit, 1'b1)
		en_put(1'b0);
		`CHK(module_enable_bit, 1'b1)
		spec = 1'b1;
		en_put(1'b0);
		`CHK(module_enable_bit, 1'b0)
		en_put(1'b1);
		spec = 1'b0;
		cfg_put(SEL_CTL1, 8'h21);
		`CHK(ctl1, CTL1_RST)
		set_init(1'b1);
		`CHK(txpin, CAN_RECESSIVE)
		@(posedge clk) rx_inc <= 1'b1;
		@(posedge clk) rx_inc <= 1'b0;
		cfg_put(SEL_REC, 8'h55);
		cfg_put(SEL_TEC, 8'h55);
		`CHK(rec, 8'h01)
		`CHK(tec, 8'h00)
		set_init(1'b0);
		for (int mi = 0; mi < 4; mi++) begin
			m = 2'(mi);
			pat = {rnd(), rnd()};
			msk = {rnd() | rnd(), rnd() | rnd()};
			set_mode(m);
			for (int i = 0; i < 8; i++) begin
				r = rnd();
				idr = (i % 4 == 0) ? {pat[7:0], pat[15:8], pat[23:16], pat[31:24]} :
					(i % 4 == 2) ? {pat[39:32], pat[47:40], pat[55:48], pat[63:56]} : r;
				timer = r[31:16];
				rxirq_en = r[0];
				e = exp_hit(m, idr);
				frame(idr, 1'b1, 1'b0, 1'b0, int'(r[2:1]));
				if (e[3]) take(idr, e[2:0]);
				`CHK(full, 1'b0)
			end
		end
		rxirq_en = 1'b1;
		msk = '1;
		set_mode(MODE_TWO);
		frame(rnd(), 1'b0, 1'b0, 1'b0, 0);
		`CHK(full, 1'b0)
		for (int i = 0; i < 6; i++) begin
			q[i] = rnd();
			frame(q[i], 1'b1, 1'b0, 1'b0, 0);
		end
		`CHK(ovr, 1'b1)
		`CHK(errirq, 1'b1)
		@(posedge clk) txbit <= 1'b1;
		tick(1);
		`CHK(txpin, 1'b1)
		@(posedge clk) txbit <= 1'b0;
		tick(1);
		`CHK(txpin, 1'b0)
		take(q[0], 3'h0);
		q[6] = rnd();
		frame(q[6], 1'b1, 1'b0, 1'b0, 1);
		for (int i = 1; i < 7; i++) if (i != 5) take(q[i], 3'h0);
		`CHK(full, 1'b0)
		@(posedge clk) ovr_clr <= 1'b1;
		@(posedge clk) ovr_clr <= 1'b0;
		tick(1);
		`CHK(ovr, 1'b0)
		frame(rnd(), 1'b1, 1'b1, 1'b0, 1);
		`CHK(full, 1'b0)
		`CHK(ack_low, 1'b1)
		idr = rnd();
		frame(idr, 1'b1, 1'b1, 1'b1, 0);
		take(idr, 3'h0);
		set_init(1'b1);
		cfg_put(SEL_CTL1, 8'h21);
		`CHK(ctl1, 8'h21)
		set_init(1'b0);
		ack_low = 1'b0;
		idr = rnd();
		frame(idr, 1'b1, 1'b1, 1'b0, 0);
		take(idr, 3'h0);
		`CHK(ack_low, 1'b0)
		@(posedge clk) pd <= 1'b1;
		tick(2);
		`CHK(txpin, CAN_RECESSIVE)
		tally_and_finish();
	end
endmodule : crf_can_rx_tb
